// [rtl/sre_dev.sv]
// Purpose: Slave end of the two-wire EEPROM, read path plus address load
// Assumes: Link lines sampled by mclk_in through three flops
// Notes: Writes only load the counter; no programming cycle is modelled
`timescale 1ns/1ps
// Operation
// RULE_01 - Master sets read bit for reads
// RULE_02 - Counter holds last accessed address plus one
// RULE_03 - Counter kept across transactions
// RULE_04 - Counter wraps from top to zero
// RULE_05 - Read address acked, current byte sent
// RULE_06 - Master NACK ends read, release SDA
// RULE_07 - Master follows NACK with Stop or Start
// RULE_08 - Random read: address write, repeated Start
// RULE_09 - Address-only write never starts programming
// RULE_10 - Ack device and word address bytes
// RULE_11 - After repeated Start send loaded byte
// RULE_12 - Master ACK advances address, next byte
// RULE_13 - Sequential read from either read type
// RULE_14 - Array reads FFh until written
// RULE_15 - Compare type nibble and three pins
// RULE_16 - Seven or eight bit word address
// RULE_17 - Bit 0 selects read or write
// RULE_18 - MSB first, SDA changes with SCL low
module sre_dev
    import sre_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic mclk_in,
    input wire logic rstn_in,
    sre_if.dev bus,
    input wire logic [2:0] pins_addr_in,
    output logic busy_out,
    output logic [7:0] addr_out
);
    typedef enum logic [2:0] {
        SRE_IDLE = 3'b000,
        SRE_DEVB = 3'b001,
        SRE_ACK = 3'b011,
        SRE_WADR = 3'b010,
        SRE_RD = 3'b110,
        SRE_MACK = 3'b111
    } sre_st_e;

    ////////////////////////////////////////////////////////////////////////
    // Line sampling; start/stop seen when stages 2 and 3 agree
    logic [SRE_SYNC_STAGES-1:0] scl_q;
    logic [SRE_SYNC_STAGES-1:0] sda_q;
    logic scl_f_q;
    logic sda_f_q;
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            scl_q <= '1;
            sda_q <= '1;
        end else begin
            scl_q <= {scl_q[1:0], bus.scl};
            sda_q <= {sda_q[1:0], bus.sda};
        end
    end
    // Filtered levels only change when the last two stages agree
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            scl_f_q <= 1'b1;
            sda_f_q <= 1'b1;
        end else begin
            if (scl_q[1] == scl_q[2]) begin
                scl_f_q <= scl_q[2];
            end
            if (sda_q[1] == sda_q[2]) begin
                sda_f_q <= sda_q[2];
            end
        end
    end
    logic scl_s;
    logic sda_s;
    assign scl_s = (scl_q[1] == scl_q[2]) ? scl_q[2] : scl_f_q;
    assign sda_s = (sda_q[1] == sda_q[2]) ? sda_q[2] : sda_f_q;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    assign scl_rise = scl_s & ~scl_f_q;
    assign scl_fall = ~scl_s & scl_f_q;
    assign start_ev = scl_s & scl_f_q & sda_f_q & ~sda_s;
    assign stop_ev = scl_s & scl_f_q & ~sda_f_q & sda_s;

    ////////////////////////////////////////////////////////////////////////
    // Array storage, erased after reset
    logic [7:0] mem_q [2**ADDR_W];
    genvar gi;
    generate
        for (gi = 0; gi < 2**ADDR_W; gi++) begin : g_mem
            always_ff @(posedge mclk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    mem_q[gi] <= SRE_ERASED; // RULE_14
                end else begin
                    mem_q[gi] <= mem_q[gi]; // Read path only; no writes land here
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Protocol engine
    sre_st_e st_q;
    logic [2:0] bit_q;
    logic [7:0] sh_q;
    logic rd_q;          // Current byte was a device address with read bit
    logic wadr_q;        // Ack slot belongs to word address
    logic [ADDR_W-1:0] ctr_q;
    logic sda_oe_q;
    logic [7:0] byte_in;
    assign byte_in = {sh_q[6:0], sda_s};
    logic match;
    assign match = (byte_in[7:4] == SRE_TYPE_ID) && (byte_in[3:1] == pins_addr_in); // RULE_15

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_q <= SRE_IDLE;
            bit_q <= 3'h0;
            sh_q <= 8'h00;
            rd_q <= 1'b0;
            wadr_q <= 1'b0;
            ctr_q <= SRE_ADDR_RST[ADDR_W-1:0];
            sda_oe_q <= 1'b0;
        end else if (stop_ev) begin
            // Stop with no data byte: counter kept, nothing programmed
            st_q <= SRE_IDLE; // RULE_09
            sda_oe_q <= 1'b0;
        end else if (start_ev) begin
            st_q <= SRE_DEVB; // RULE_11
            bit_q <= 3'h0;
            sda_oe_q <= 1'b0;
        end else begin
            case (st_q)
                SRE_DEVB, SRE_WADR: begin
                    if (scl_rise) begin
                        sh_q <= byte_in;
                        bit_q <= bit_q + 3'h1;
                        if (bit_q == 3'(SRE_BIT_LAST)) begin
                            if (st_q == SRE_WADR) begin
                                // Word address loads the counter only
                                ctr_q <= byte_in[ADDR_W-1:0]; // RULE_16
                                wadr_q <= 1'b1;
                                st_q <= SRE_ACK; // RULE_10
                            end else if (match) begin
                                rd_q <= byte_in[0]; // RULE_17
                                wadr_q <= 1'b0;
                                st_q <= SRE_ACK; // RULE_05
                            end else begin
                                st_q <= SRE_IDLE;
                            end
                        end
                    end
                end
                SRE_ACK: begin
                    // Drive ack from the falling edge; the next one releases it or puts out the first read bit
                    if (scl_fall) begin
                        if (!sda_oe_q) begin
                            sda_oe_q <= 1'b1; // RULE_10
                        end else if (rd_q && !wadr_q) begin
                            sh_q <= mem_q[ctr_q]; // RULE_05
                            ctr_q <= ctr_q + ADDR_W'(1); // RULE_02 RULE_04
                            sda_oe_q <= ~mem_q[ctr_q][7]; // RULE_18
                            bit_q <= 3'h0;
                            st_q <= SRE_RD;
                        end else begin
                            sda_oe_q <= 1'b0;
                            bit_q <= 3'h0;
                            // Extra bytes after word address are ignored
                            st_q <= wadr_q ? SRE_IDLE : SRE_WADR; // RULE_09
                        end
                    end
                end
                SRE_RD: begin
                    if (scl_fall) begin
                        if (bit_q == 3'(SRE_BIT_LAST)) begin
                            sda_oe_q <= 1'b0;
                            st_q <= SRE_MACK;
                        end else begin
                            sh_q <= {sh_q[6:0], 1'b0};
                            sda_oe_q <= ~sh_q[6]; // RULE_18
                            bit_q <= bit_q + 3'h1;
                        end
                    end
                end
                SRE_MACK: begin
                    // Master's slot: no ack of our own, an acked byte is followed at once
                    if (scl_rise && sda_s) begin
                        st_q <= SRE_IDLE; // RULE_06
                    end else if (scl_fall) begin
                        sh_q <= mem_q[ctr_q]; // RULE_12 RULE_13
                        ctr_q <= ctr_q + ADDR_W'(1); // RULE_04
                        sda_oe_q <= ~mem_q[ctr_q][7];
                        bit_q <= 3'h0;
                        st_q <= SRE_RD;
                    end
                end
                default: begin
                    st_q <= SRE_IDLE;
                end
            endcase
        end
    end

    // Reported state; counter persists until reset
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            busy_out <= 1'b0;
            addr_out <= 8'h00;
        end else begin
            busy_out <= (st_q != SRE_IDLE);
            addr_out <= 8'(ctr_q); // RULE_03
        end
    end
    assign bus.sda_s_oe = sda_oe_q;
endmodule

// [rtl/sre_if.sv]
// Purpose: Two-wire link between the bus master and the EEPROM read path
// Assumes: Open-drain wires; any enabled driver pulls low
// Notes: Pull-up modelled as default high level
`timescale 1ns/1ps
interface sre_if;
    logic scl_m_oe;
    logic sda_m_oe;
    logic sda_s_oe;
    logic scl;
    logic sda;
    // Wired-AND resolution of the open-drain lines
    assign scl = ~scl_m_oe;
    assign sda = ~(sda_m_oe | sda_s_oe);
    modport dev (input scl, input sda, output sda_s_oe);
    modport mst (input scl, input sda, output scl_m_oe, output sda_m_oe);
endinterface

// [rtl/sre_mst.sv]
// Purpose: Bus master end issuing current, random and sequential reads
// Assumes: Single master; slave never stretches the clock
// Notes: Link clock derived from mclk_in by a divider
`timescale 1ns/1ps
module sre_mst
    import sre_pkg::*;
#(
    parameter logic [2:0] PINS = 3'h0
) (
    input wire logic mclk_in,
    input wire logic rstn_in,
    sre_if.mst bus,
    input wire logic req_in,
    input wire logic [1:0] op_in,
    input wire logic [7:0] waddr_in,
    input wire logic [7:0] len_in,
    output logic [7:0] data_out,
    output logic data_vld_out,
    output logic done_out,
    output logic nack_out
);
    typedef enum logic [2:0] {
        M_IDLE = 3'b000,
        M_START = 3'b001,
        M_BYTE = 3'b011,
        M_RBYTE = 3'b010,
        M_STOP = 3'b110
    } m_st_e;

    ////////////////////////////////////////////////////////////////////////
    // Clock divider: each phase lasts SRE_SCL_HALF_CYC cycles
    logic [7:0] div_q;
    logic tick;
    assign tick = (div_q == 8'(SRE_SCL_HALF_CYC - 1));
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            div_q <= 8'h00;
        end else begin
            div_q <= tick ? 8'h00 : div_q + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // SDA from the far end passes three flops; level taken once the last two agree
    logic [SRE_SYNC_STAGES-1:0] sda_q;
    logic sda_f_q;
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sda_q <= '1;
            sda_f_q <= 1'b1;
        end else begin
            sda_q <= {sda_q[1:0], bus.sda};
            if (sda_q[1] == sda_q[2]) begin
                sda_f_q <= sda_q[2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer; ph_q steps 0..3 per bit: low, low-mid, high, high-end
    m_st_e st_q;
    logic [1:0] ph_q;
    logic [3:0] bit_q;
    logic [7:0] tx_q;
    logic [7:0] rx_q;
    logic [7:0] left_q;
    logic [1:0] op_q;
    logic [1:0] stage_q;   // 0 dev addr, 1 word addr, 2 read dev addr
    logic scl_oe_q;
    logic sda_oe_q;
    logic [7:0] addr_w;
    logic [7:0] addr_r;
    assign addr_w = {SRE_TYPE_ID, PINS, 1'b0};
    assign addr_r = {SRE_TYPE_ID, PINS, 1'b1}; // RULE_01

    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_q <= M_IDLE;
            ph_q <= 2'h0;
            bit_q <= 4'h0;
            tx_q <= 8'h00;
            rx_q <= 8'h00;
            left_q <= 8'h00;
            op_q <= SRE_OP_CUR;
            stage_q <= 2'h0;
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
            data_out <= 8'h00;
            data_vld_out <= 1'b0;
            done_out <= 1'b0;
            nack_out <= 1'b0;
        end else begin
            data_vld_out <= 1'b0;
            done_out <= 1'b0;
            case (st_q)
                M_IDLE: begin
                    if (req_in) begin
                        op_q <= op_in;
                        left_q <= len_in;
                        nack_out <= 1'b0;
                        stage_q <= (op_in == SRE_OP_CUR) ? 2'h2 : 2'h0;
                        ph_q <= 2'h0;
                        st_q <= M_START;
                    end
                end
                M_START: begin
                    // SDA falls with SCL high, then SCL goes low
                    if (tick) begin
                        ph_q <= ph_q + 2'h1;
                        if (ph_q == 2'h0) begin
                            scl_oe_q <= 1'b0;
                            sda_oe_q <= 1'b0;
                        end else if (ph_q == 2'h1) begin
                            sda_oe_q <= 1'b1;
                        end else if (ph_q == 2'h2) begin
                            scl_oe_q <= 1'b1;
                            tx_q <= (stage_q == 2'h2) ? addr_r : addr_w; // RULE_08
                            bit_q <= 4'h0;
                            ph_q <= 2'h0;
                            st_q <= M_BYTE;
                        end
                    end
                end
                M_BYTE, M_RBYTE: begin
                    if (tick) begin
                        ph_q <= ph_q + 2'h1;
                        case (ph_q)
                            2'h0: begin
                                if (st_q == M_BYTE) begin
                                    sda_oe_q <= (bit_q < 4'h8) ? ~tx_q[7] : 1'b0;
                                end else if (bit_q < 4'h8) begin
                                    sda_oe_q <= 1'b0;
                                end else begin
                                    // Ack keeps the read going, NACK ends it
                                    sda_oe_q <= (left_q > 8'h01); // RULE_13 RULE_07
                                end
                            end
                            2'h1: scl_oe_q <= 1'b0;
                            2'h2: begin
                                if (bit_q < 4'h8) begin
                                    tx_q <= {tx_q[6:0], 1'b0};
                                    rx_q <= {rx_q[6:0], sda_f_q};
                                end else if (st_q == M_BYTE && sda_f_q) begin
                                    nack_out <= 1'b1;
                                end
                            end
                            default: begin
                                scl_oe_q <= 1'b1;
                                bit_q <= bit_q + 4'h1;
                                if (bit_q == 4'h8) begin
                                    bit_q <= 4'h0;
                                    if (st_q == M_RBYTE) begin
                                        data_out <= rx_q;
                                        data_vld_out <= 1'b1;
                                        left_q <= left_q - 8'h01;
                                        if (left_q <= 8'h01) begin
                                            st_q <= M_STOP;
                                        end
                                    end else if (nack_out) begin
                                        st_q <= M_STOP;
                                    end else if (stage_q == 2'h0) begin
                                        tx_q <= waddr_in;
                                        stage_q <= 2'h1;
                                    end else if (stage_q == 2'h1) begin
                                        // Omit data: repeated Start for a random read, Stop for a load-only op
                                        stage_q <= 2'h2;
                                        st_q <= (op_q == SRE_OP_WRADDR) ? M_STOP : M_START; // RULE_08
                                    end else begin
                                        st_q <= (left_q == 8'h00) ? M_STOP : M_RBYTE;
                                    end
                                end
                            end
                        endcase
                    end
                end
                M_STOP: begin
                    // SDA low, SCL released, then SDA released
                    if (tick) begin
                        ph_q <= ph_q + 2'h1;
                        if (ph_q == 2'h0) begin
                            sda_oe_q <= 1'b1;
                        end else if (ph_q == 2'h1) begin
                            scl_oe_q <= 1'b0;
                        end else if (ph_q == 2'h2) begin
                            sda_oe_q <= 1'b0; // RULE_07
                            done_out <= 1'b1;
                            ph_q <= 2'h0;
                            st_q <= M_IDLE;
                        end
                    end
                end
                default: begin
                    st_q <= M_IDLE;
                end
            endcase
        end
    end
    assign bus.scl_m_oe = scl_oe_q;
    assign bus.sda_m_oe = sda_oe_q;
endmodule

// [rtl/sre_pkg.sv]
// Purpose: Shared constants for the serial EEPROM read path
// Assumes: Two-wire bus, device clock 20 MHz, link clock sampled as data
// Notes: Both ends import this package whole
package sre_pkg;
    localparam logic [3:0] SRE_TYPE_ID = 4'ha;      // Device type identifier, upper nibble
    localparam logic [7:0] SRE_ERASED = 8'hff;      // Array content as shipped
    localparam logic [7:0] SRE_ADDR_RST = 8'h00;    // Counter value after reset
    localparam int SRE_SYNC_STAGES = 3;
    localparam int SRE_BIT_LAST = 7;                // Index of last bit in a byte
    localparam int SRE_CLK_NS = 50;
    localparam int SRE_SCL_HALF_NS = 1250;          // One sequencer phase, a quarter period of the driven link clock
    localparam int SRE_SCL_HALF_CYC = (SRE_SCL_HALF_NS + SRE_CLK_NS - 1) / SRE_CLK_NS;
    localparam logic [1:0] SRE_OP_CUR = 2'h0;       // Master ops
    localparam logic [1:0] SRE_OP_RAND = 2'h1;
    localparam logic [1:0] SRE_OP_WRADDR = 2'h2;
endpackage

// [testbench/sre_monitor.sv]
// Purpose: Wire-level checks on the two-wire link between both ends
// Assumes: Array never written, so every data byte reads as erased
// Notes: Frame position is rebuilt here from the raw wires
`timescale 1ns/1ps
module sre_monitor
    import sre_pkg::*;
(
    input wire logic mclk_in,
    input wire logic [2:0] pins_in, // Device's own address pins, may differ from the master's
    input wire logic rstn_in,
    input wire logic scl_m_oe,
    input wire logic sda_m_oe,
    input wire logic sda_s_oe,
    input wire logic scl,
    input wire logic sda
);
    logic scl_p_q, sda_p_q, rd_q, ack_q, quiet_q;
    logic rise, start, stop, hit, dslot;
    logic [3:0] bit_q;
    logic [2:0] byte_q;
    logic [7:0] sh_q;
    logic [4:0] lo_q;
    ////////////////////////////////////////////////////////////////
    // Edge and condition detection on the resolved wires
    assign rise = scl & ~scl_p_q;
    assign start = scl & scl_p_q & sda_p_q & ~sda;
    assign stop = scl & scl_p_q & ~sda_p_q & sda;
    assign hit = sh_q[7:1] == {SRE_TYPE_ID, pins_in};
    // After a nack the next rise belongs to a Stop, not to a data bit
    assign dslot = rise && (bit_q < 4'h8) && (byte_q != 3'h0) && ack_q && !quiet_q;
    // Low-time counter, saturates so long clock-low times cannot wrap
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            lo_q <= 5'h00;
        end else begin
            scl_p_q <= scl;
            sda_p_q <= sda;
            lo_q <= scl ? 5'h00 : ((lo_q == 5'h1f) ? lo_q : lo_q + 5'h01);
        end
    end
    // Bit and byte position within a frame; a start always resyncs
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bit_q <= 4'h0;
            byte_q <= 3'h0;
            sh_q <= 8'h00;
            rd_q <= 1'b0;
            ack_q <= 1'b0;
            quiet_q <= 1'b0;
        end else if (start) begin
            bit_q <= 4'h0;
            byte_q <= 3'h0;
            rd_q <= 1'b0;
            ack_q <= 1'b0;
            quiet_q <= 1'b0;
        end else if (stop) begin
            quiet_q <= 1'b0;
        end else if (rise && bit_q == 4'h8) begin
            bit_q <= 4'h0;
            byte_q <= (byte_q == 3'h7) ? byte_q : byte_q + 3'h1;
            if (byte_q == 3'h0) begin
                rd_q <= sh_q[0];
                ack_q <= hit;
                quiet_q <= ~hit;
            end else if (rd_q && sda) begin
                quiet_q <= 1'b1;
            end
        end else if (rise) begin
            bit_q <= bit_q + 4'h1;
            sh_q <= {sh_q[6:0], sda};
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    AST_ADDR_ACK: assert property (rise && bit_q == 4'h8 && byte_q == 3'h0 |-> sda_s_oe == hit)
        else $error("address ack does not follow the address match");
    AST_WADDR_ACK: assert property (rise && bit_q == 4'h8 && byte_q == 3'h1 && ack_q && !rd_q |-> sda_s_oe)
        else $error("word address byte not acknowledged");
    AST_DATA_ONES: assert property (dslot && rd_q |-> sda && !sda_m_oe)
        else $error("read data bit not one");
    AST_WR_LISTEN: assert property (dslot && !rd_q |-> !sda_s_oe)
        else $error("device drives during a write byte");
    AST_MST_SLOT: assert property (rise && bit_q == 4'h8 && byte_q != 3'h0 && rd_q && ack_q |-> !sda_s_oe)
        else $error("device holds the master ack slot");
    AST_QUIET: assert property (quiet_q |-> !sda_s_oe)
        else $error("device drives after nack or mismatch");
    AST_SCL_LOW: assert property ($changed(sda_s_oe) |-> !scl)
        else $error("device data changed with clock high");
    AST_TURN: assert property ($changed(sda_s_oe) |-> lo_q inside {[1:8]})
        else $error("device data change not just after clock fall");
    AST_START_FREE: assert property (start |=> !sda_s_oe [*4])
        else $error("device drives right after a start");
    // Main scenarios reached
    cover property (rise && bit_q == 4'h8 && byte_q >= 3'h2 && rd_q && !sda);
    cover property (start && byte_q == 3'h2);
    cover property (quiet_q && !ack_q);
    cover property (stop && !rd_q && byte_q == 3'h2);
endmodule

// [testbench/testbench.sv]
// Purpose: Drives reads through the master end against the device end
// Assumes: Array as shipped; counter tracked by a bench model
// Notes: Random ops mixed with wrap, load-only and mismatch cases
`timescale 1ns/1ps
module testbench
    import sre_pkg::*;
;
    localparam logic [2:0] MPINS = 3'h5;
    logic mclk_in, rstn_in, req_in, data_vld_out, done_out, nack_out, busy_out;
    logic [1:0] op_in, rop;
    logic [7:0] waddr_in, len_in, data_out, addr_out, model_addr;
    logic [2:0] pins_addr_in;
    int error_cnt, n_compared, i;
    integer seed;
    sre_if i_sre_if();
    sre_dev #(.ADDR_W(8)) i_sre_dev (.mclk_in(mclk_in), .rstn_in(rstn_in), .bus(i_sre_if.dev),
        .pins_addr_in(pins_addr_in), .busy_out(busy_out), .addr_out(addr_out));
    sre_mst #(.PINS(MPINS)) i_sre_mst (.mclk_in(mclk_in), .rstn_in(rstn_in), .bus(i_sre_if.mst),
        .req_in(req_in), .op_in(op_in), .waddr_in(waddr_in), .len_in(len_in), .data_out(data_out),
        .data_vld_out(data_vld_out), .done_out(done_out), .nack_out(nack_out));
    sre_monitor i_sre_monitor (.mclk_in(mclk_in), .rstn_in(rstn_in), .pins_in(pins_addr_in),
        .scl_m_oe(i_sre_if.scl_m_oe), .sda_m_oe(i_sre_if.sda_m_oe), .sda_s_oe(i_sre_if.sda_s_oe),
        .scl(i_sre_if.scl), .sda(i_sre_if.sda));
    ////////////////////////////////////////////////////////////////
    initial begin
        mclk_in = 1'b0;
        forever #25 mclk_in = ~mclk_in;
    end
    // Counter after an op; a load-only op ignores the length
    function automatic logic [7:0] exp_addr(input logic [1:0] op, input logic [7:0] cur, wa, n);
        case (op)
            SRE_OP_CUR: exp_addr = cur + n;
            SRE_OP_RAND: exp_addr = wa + n;
            default: exp_addr = wa;
        endcase
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // One master op; the wait is bounded so a hung link still ends the run
    task automatic do_op(input string name, input logic [1:0] op, input logic [7:0] wa, n, input logic hit);
        int k;
        int got;
        logic [7:0] ea;
        logic [7:0] eb;
        ea = hit ? exp_addr(op, model_addr, wa, n) : model_addr;
        eb = (!hit || op == SRE_OP_WRADDR) ? 8'h00 : n;
        got = 0;
        @(posedge mclk_in);
        req_in <= 1'b1;
        op_in <= op;
        waddr_in <= wa;
        len_in <= n;
        @(posedge mclk_in);
        req_in <= 1'b0;
        for (k = 0; k < 12000; k++) begin
            @(posedge mclk_in);
            #1;
            if (data_vld_out === 1'b1) begin
                check("data", data_out, SRE_ERASED);
                got++;
            end
            if (done_out === 1'b1)
                break;
        end
        if (k == 12000) begin
            error_cnt++;
            $display("ERROR %s expected done seen timeout", name);
            conclude();
        end
        // Let the device see the stop through its synchronisers
        repeat (10) @(posedge mclk_in);
        #1;
        check("bytes", 8'(got), eb);
        check("addr", addr_out, ea);
        check("nack", {7'h0, nack_out}, {7'h0, ~hit});
        check("busy", {7'h0, busy_out}, 8'h00);
        model_addr = ea;
        $display("test %s done", name);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        seed = 53038;
        error_cnt = 0;
        n_compared = 0;
        rstn_in = 1'b0;
        req_in = 1'b0;
        op_in = 2'h0;
        waddr_in = 8'h00;
        len_in = 8'h00;
        pins_addr_in = MPINS;
        model_addr = SRE_ADDR_RST;
        repeat (8) @(posedge mclk_in);
        rstn_in <= 1'b1;
        do_op("cur_first", SRE_OP_CUR, 8'h00, 8'h01, 1'b1);
        do_op("cur_seq", SRE_OP_CUR, 8'h00, 8'h03, 1'b1);
        do_op("rand_wrap", SRE_OP_RAND, 8'hfe, 8'h03, 1'b1);
        do_op("load_top", SRE_OP_WRADDR, 8'hff, 8'h00, 1'b1);
        do_op("cur_wrap", SRE_OP_CUR, 8'h00, 8'h02, 1'b1);
        for (i = 0; i < 6; i++) begin
            // Unsigned first, a negative remainder would give the undecoded op 3
            rop = 2'($unsigned($random(seed)) % 3);
            do_op("random", rop, 8'($random(seed)), 8'h01 + 8'($random(seed) & 3), 1'b1);
        end
        @(posedge mclk_in);
        pins_addr_in <= MPINS ^ 3'h4;
        do_op("pins_mismatch", SRE_OP_CUR, 8'h00, 8'h01, 1'b0);
        @(posedge mclk_in);
        pins_addr_in <= MPINS;
        rstn_in <= 1'b0;
        repeat (3) @(posedge mclk_in);
        #1;
        check("addr_rst", addr_out, SRE_ADDR_RST);
        @(posedge mclk_in);
        rstn_in <= 1'b1;
        model_addr = SRE_ADDR_RST;
        do_op("after_reset", SRE_OP_RAND, 8'h7f, 8'h02, 1'b1);
        conclude();
    end
endmodule
